// file: inc/clkgen_defines.svh
`ifndef CLKGEN_DEFINES_SVH
`define CLKGEN_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_OUT_A          15'h5064
`define IDX_OUT_B          15'h5065
`define IDX_SETTLE         15'h507d
`define IDX_PCLK_GATE      15'h5080
`define IDX_CORE_GEAR      15'h5081

// Reset values
`define RST_OUT_A          8'h00
`define RST_OUT_B          8'h00
`define RST_SETTLE         8'h00
`define RST_PCLK_GATE      8'h03
`define RST_CORE_GEAR      8'h00

// Clock output control fields
`define OUT_DIV_HI         6
`define OUT_DIV_LO         4
`define OUT_SRC_HI         3
`define OUT_SRC_LO         2
`define OUT_EN_BIT         0

// Settle wait fields
`define FAST_WT_HI         7
`define FAST_WT_LO         6
`define SLOW_WT_HI         1
`define SLOW_WT_LO         0

// Gate and gear fields
`define GATE_HI            1
`define GATE_LO            0
`define GEAR_HI            1
`define GEAR_LO            0

// Source codes
`define SRC_FAST           2'h0
`define SRC_SLOW           2'h1

// Peripheral gate codes
`define GATE_ON            2'h3
`define GATE_OFF           2'h0

// Settle counts in oscillator cycles
`define FAST_WAIT_0        15'h0040
`define FAST_WAIT_1        15'h0020
`define FAST_WAIT_2        15'h0010
`define FAST_WAIT_3        15'h0008
`define SLOW_WAIT_0        32'h0000_4000
`define SLOW_WAIT_2        32'h0000_1000
`define SLOW_WT_CODE_SHORT 2'h2

`endif

// file: inc/clkgen_pkg.sv
package clkgen_pkg;
  // One register byte
  typedef logic [7:0]  reg_byte_t;
  // Source select field
  typedef logic [1:0]  src_sel_t;
  // Settle counter
  typedef logic [14:0] settle_cnt_t;
endpackage

// file: inc/osc_if.sv
`timescale 1ns/1ps
`default_nettype none
// Oscillator tick and its settled flag
interface osc_if;
  logic tick;   // One pulse per oscillator cycle
  logic on;     // Oscillator running
  logic ready;  // Settle wait expired
  modport settle (input tick, input on, output ready);
  modport user   (input tick, input ready);
endinterface
`default_nettype wire

// file: rtl/clock_output_and_gating_control.sv
// Operation
// - Output A divides source by 2^code
// - Output A source: fast or slow oscillator
// - Outputs A and B run only while enable bit set
// - Output B divides source by 2^code
// - Output B source: fast or slow oscillator
// - Fast oscillator waits 64/32/16/8 cycles
// - Slow oscillator waits 16384 or 4096 cycles
// - Peripheral clock on at 3, off at 0
// - Core clock geared 1/1 to 1/8
// - System clock from fast or slow oscillator
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_defines.svh"
module clock_output_and_gating_control #(
  parameter int SLOW_WAIT_LONG  = `SLOW_WAIT_0,
  parameter int SLOW_WAIT_SHORT = `SLOW_WAIT_2
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [16:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Oscillator ticks and run levels
  input  wire logic        fast_osc_tick,
  input  wire logic        fast_osc_on,
  input  wire logic        slow_osc_tick,
  input  wire logic        slow_osc_on,
  input  wire logic [1:0]  system_clock_source,
  // Clock outputs A, B and core pulse once per divided period; gate and ready flags are levels
  output logic             clock_out_a,
  output logic             clock_out_b,
  output logic             core_clock,
  output logic             peripheral_clock_on,
  output logic             fast_osc_ready,
  output logic             slow_osc_ready
);

  // Register fields
  logic [2:0]           out_a_divider;     // Output A ratio code
  clkgen_pkg::src_sel_t out_a_source;      // Output A source
  logic                 out_a_enable;      // Output A enable
  logic [2:0]           out_b_divider;     // Output B ratio code
  clkgen_pkg::src_sel_t out_b_source;      // Output B source
  logic                 out_b_enable;      // Output B enable
  logic [1:0]           fast_osc_settle_count;  // Fast wait code
  logic [1:0]           slow_osc_settle_count;  // Slow wait code
  logic [1:0]           peripheral_clock_gate_code;  // Gate code
  logic [1:0]           core_gear_ratio;   // Core gear code

  // Bus decode
  logic                 req;          // Request pending, no ack yet
  logic                 wr_lo;        // Write to the low byte lane
  logic [14:0]          idx;          // Register index
  clkgen_pkg::reg_byte_t rd_byte;     // Selected read value
  clkgen_pkg::reg_byte_t wr_byte;     // Low write byte

  // Oscillator paths
  osc_if                   fast_osc ();
  osc_if                   slow_osc ();
  clkgen_pkg::settle_cnt_t fast_wait;   // Fast settle count
  clkgen_pkg::settle_cnt_t slow_wait;   // Slow settle count
  logic                    fast_gated;  // Settled fast ticks
  logic                    slow_gated;  // Settled slow ticks
  logic                    a_tick;      // Output A source ticks
  logic                    b_tick;      // Output B source ticks
  logic                    sys_tick;    // System clock ticks
  logic                    a_div;       // Divided output A
  logic                    b_div;       // Divided output B
  logic                    core_div;    // Geared core ticks

  // Request seen once, ack drops the cycle after
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lo = req && wb_we_i && wb_sel_i[0];
  assign idx   = wb_adr_i[16:2];
  assign wr_byte = wb_dat_i[7:0];

  // Output A control register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      out_a_divider <= 3'(`RST_OUT_A >> `OUT_DIV_LO);
      out_a_source  <= 2'h0;
      out_a_enable  <= 1'b0;
    end else if (wr_lo && idx == `IDX_OUT_A) begin
      out_a_divider <= wr_byte[`OUT_DIV_HI:`OUT_DIV_LO];
      out_a_source  <= wr_byte[`OUT_SRC_HI:`OUT_SRC_LO];
      out_a_enable  <= wr_byte[`OUT_EN_BIT];
    end
  end

  // Output B control register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      out_b_divider <= 3'(`RST_OUT_B >> `OUT_DIV_LO);
      out_b_source  <= 2'h0;
      out_b_enable  <= 1'b0;
    end else if (wr_lo && idx == `IDX_OUT_B) begin
      out_b_divider <= wr_byte[`OUT_DIV_HI:`OUT_DIV_LO];
      out_b_source  <= wr_byte[`OUT_SRC_HI:`OUT_SRC_LO];
      out_b_enable  <= wr_byte[`OUT_EN_BIT];
    end
  end

  // Settle wait register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fast_osc_settle_count <= 2'h0;
      slow_osc_settle_count <= 2'h0;
    end else if (wr_lo && idx == `IDX_SETTLE) begin
      fast_osc_settle_count <= wr_byte[`FAST_WT_HI:`FAST_WT_LO];
      slow_osc_settle_count <= wr_byte[`SLOW_WT_HI:`SLOW_WT_LO];
    end
  end

  // Peripheral gate; forbidden codes leave the gate as it was
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      peripheral_clock_gate_code <= 2'(`RST_PCLK_GATE);
    end else if (wr_lo && idx == `IDX_PCLK_GATE) begin
      if (wr_byte[`GATE_HI:`GATE_LO] == `GATE_ON ||
          wr_byte[`GATE_HI:`GATE_LO] == `GATE_OFF) begin
        peripheral_clock_gate_code <= wr_byte[`GATE_HI:`GATE_LO];
      end
    end
  end

  // Core gear register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      core_gear_ratio <= 2'h0;
    end else if (wr_lo && idx == `IDX_CORE_GEAR) begin
      core_gear_ratio <= wr_byte[`GEAR_HI:`GEAR_LO];
    end
  end

  // Read mux; reserved bits and unmapped words read zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      `IDX_OUT_A: begin
        rd_byte = {1'b0, out_a_divider, out_a_source, 1'b0, out_a_enable};
      end
      `IDX_OUT_B: begin
        rd_byte = {1'b0, out_b_divider, out_b_source, 1'b0, out_b_enable};
      end
      `IDX_SETTLE: begin
        rd_byte = {fast_osc_settle_count, 4'h0, slow_osc_settle_count};
      end
      `IDX_PCLK_GATE: begin
        rd_byte = {6'h00, peripheral_clock_gate_code};
      end
      `IDX_CORE_GEAR: begin
        rd_byte = {6'h00, core_gear_ratio};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Bus answer one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Read data captured with the ack
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // Fast settle count from its code
  always_comb begin
    unique case (fast_osc_settle_count)
      2'h0: fast_wait = `FAST_WAIT_0;
      2'h1: fast_wait = `FAST_WAIT_1;
      2'h2: fast_wait = `FAST_WAIT_2;
      2'h3: fast_wait = `FAST_WAIT_3;
    endcase
  end

  // Slow settle count; reserved codes take the long wait
  always_comb begin
    if (slow_osc_settle_count == `SLOW_WT_CODE_SHORT) begin
      slow_wait = 15'(SLOW_WAIT_SHORT);
    end else begin
      slow_wait = 15'(SLOW_WAIT_LONG);
    end
  end

  // Oscillator run levels and ticks into the settle blocks
  assign fast_osc.tick = fast_osc_tick;
  assign fast_osc.on   = fast_osc_on;
  assign slow_osc.tick = slow_osc_tick;
  assign slow_osc.on   = slow_osc_on;

  // Wait counted in cycles of each oscillator
  osc_settle u_fast_settle (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .wait_cycles (fast_wait),
    .osc         (fast_osc)
  );

  osc_settle u_slow_settle (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .wait_cycles (slow_wait),
    .osc         (slow_osc)
  );

  // Ticks released only after settling
  assign fast_gated = fast_osc.tick && fast_osc.ready;
  assign slow_gated = slow_osc.tick && slow_osc.ready;

  // Source select per output; reserved codes give no ticks
  always_comb begin
    a_tick = 1'b0;
    b_tick = 1'b0;
    if (out_a_source == `SRC_FAST) begin
      a_tick = fast_gated;
    end else if (out_a_source == `SRC_SLOW) begin
      a_tick = slow_gated;
    end
    if (out_b_source == `SRC_FAST) begin
      b_tick = fast_gated;
    end else if (out_b_source == `SRC_SLOW) begin
      b_tick = slow_gated;
    end
  end

  // System clock source; reserved codes fall back to fast
  always_comb begin
    if (system_clock_source == `SRC_SLOW) begin
      sys_tick = slow_gated;
    end else begin
      sys_tick = fast_gated;
    end
  end

  // Output A divider, held cleared while disabled
  pow2_divider #(.RW(3)) u_div_a (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .enable   (out_a_enable),
    .tick_in  (a_tick),
    .ratio    (out_a_divider),
    .tick_out (a_div)
  );

  // Output B divider
  pow2_divider #(.RW(3)) u_div_b (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .enable   (out_b_enable),
    .tick_in  (b_tick),
    .ratio    (out_b_divider),
    .tick_out (b_div)
  );

  // Core clock gear
  pow2_divider #(.RW(2)) u_gear (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .enable   (1'b1),
    .tick_in  (sys_tick),
    .ratio    (core_gear_ratio),
    .tick_out (core_div)
  );

  // Clock outputs, forced low while disabled
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      clock_out_a <= 1'b0;
      clock_out_b <= 1'b0;
    end else begin
      clock_out_a <= a_div && out_a_enable;
      clock_out_b <= b_div && out_b_enable;
    end
  end

  // Core clock pulses
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      core_clock <= 1'b0;
    end else begin
      core_clock <= core_div;
    end
  end

  // Peripheral clock supply level
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      peripheral_clock_on <= 1'b0;
    end else begin
      peripheral_clock_on <= peripheral_clock_gate_code == `GATE_ON;
    end
  end

  // Settled flags brought out
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fast_osc_ready <= 1'b0;
      slow_osc_ready <= 1'b0;
    end else begin
      fast_osc_ready <= fast_osc.ready;
      slow_osc_ready <= slow_osc.ready;
    end
  end

endmodule // clock_output_and_gating_control
`default_nettype wire

// file: rtl/osc_settle.sv
`timescale 1ns/1ps
`default_nettype none
// Holds an oscillator back until its wait count expires
module osc_settle (
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  input  wire clkgen_pkg::settle_cnt_t wait_cycles,
  osc_if.settle                      osc
);
  clkgen_pkg::settle_cnt_t cnt_r;  // Oscillator cycles seen
  logic                    rdy_r;  // Settled

  // Count in oscillator cycles; restart when stopped
  always_ff @(posedge clk_sys) begin
    if (!resetn || !osc.on) begin
      cnt_r <= '0;
      rdy_r <= 1'b0;
    end else if (osc.tick && !rdy_r) begin
      cnt_r <= cnt_r + 15'h0001;
      if (cnt_r + 15'h0001 >= wait_cycles) begin
        rdy_r <= 1'b1;
      end
    end
  end

  assign osc.ready = rdy_r;
endmodule // osc_settle
`default_nettype wire

// file: rtl/pow2_divider.sv
`timescale 1ns/1ps
`default_nettype none
// Power-of-two divider on a tick stream
module pow2_divider #(
  parameter int RW = 3
) (
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  input  wire logic          enable,
  input  wire logic          tick_in,
  input  wire logic [RW-1:0] ratio,
  output logic               tick_out
);
  localparam int CW = (1 << RW) - 1;

  logic [CW-1:0] cnt_r;  // Source tick count
  logic [CW-1:0] mask;   // Low bits that must be full

  // Ratio code n keeps n low bits
  always_comb begin
    mask = CW'((1 << ratio) - 1);
  end

  // Count source ticks while enabled
  always_ff @(posedge clk_sys) begin
    if (!resetn || !enable) begin
      cnt_r <= '0;
    end else if (tick_in) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // One output pulse per 2^n source ticks
  always_ff @(posedge clk_sys) begin
    if (!resetn || !enable) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && ((cnt_r & mask) == mask);
    end
  end
endmodule // pow2_divider
`default_nettype wire

// file: tb/clkgen_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_defines.svh"
// Bus and clock output checks, fed only by the top ports
module clkgen_assertions #(
  parameter int SLOW_WAIT_LONG  = `SLOW_WAIT_0,
  parameter int SLOW_WAIT_SHORT = `SLOW_WAIT_2
) (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [16:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        fast_osc_tick,
  input wire logic        fast_osc_on,
  input wire logic        slow_osc_tick,
  input wire logic        slow_osc_on,
  input wire logic        clock_out_a,
  input wire logic        clock_out_b,
  input wire logic        peripheral_clock_on,
  input wire logic        fast_osc_ready,
  input wire logic        slow_osc_ready
);
  logic [7:0]  a_r;   // Output A control copy
  logic [7:0]  b_r;   // Output B control copy
  logic [7:0]  st_r;  // Settle wait copy
  logic [1:0]  g_r;   // Peripheral gate copy
  logic [15:0] fc_r;  // Fast ticks since start
  logic [15:0] sc_r;  // Slow ticks since start
  logic        wr;    // Write taken at this edge
  logic [15:0] fw;    // Expected fast wait
  logic [15:0] sw;    // Expected slow wait
  assign wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  assign fw = 16'h0040 >> st_r[7:6];
  assign sw = (st_r[1:0] == 2'h2) ? 16'(SLOW_WAIT_SHORT) : 16'(SLOW_WAIT_LONG);
  // Register copies from taken writes; reserved bits masked off
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      a_r <= 8'h00;
      b_r <= 8'h00;
      st_r <= 8'h00;
      g_r <= 2'h3;
    end else if (wr) begin
      case (wb_adr_i[16:2])
        `IDX_OUT_A: a_r <= wb_dat_i[7:0] & 8'h7d;
        `IDX_OUT_B: b_r <= wb_dat_i[7:0] & 8'h7d;
        `IDX_SETTLE: st_r <= wb_dat_i[7:0] & 8'hc3;
        `IDX_PCLK_GATE: if (wb_dat_i[1:0] == 2'h0 || wb_dat_i[1:0] == 2'h3) g_r <= wb_dat_i[1:0];
        default: ;
      endcase
    end
  end
  // Fast ticks counted while running
  always_ff @(posedge clk_sys) begin
    if (!resetn || !fast_osc_on) fc_r <= 16'h0000;
    else if (fast_osc_tick) fc_r <= fc_r + 16'h0001;
  end
  // Slow ticks counted while running
  always_ff @(posedge clk_sys) begin
    if (!resetn || !slow_osc_on) sc_r <= 16'h0000;
    else if (slow_osc_tick) sc_r <= sc_r + 16'h0001;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  rd_out_a_a:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i[16:2] == `IDX_OUT_A |-> wb_dat_o == {24'h000000, a_r})
      else $error("output A readback wrong");
  rd_settle_a:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i[16:2] == `IDX_SETTLE |-> wb_dat_o == {24'h000000, st_r})
      else $error("settle readback wrong");
  out_a_off_a:
    assert property ((!a_r[0] || a_r[3])[*3] |-> !clock_out_a) else $error("output A runs while off");
  out_b_off_a:
    assert property ((!b_r[0] || b_r[3])[*3] |-> !clock_out_b) else $error("output B runs while off");
  pclk_follow_a:
    assert property ($past(resetn) |-> peripheral_clock_on == $past(g_r == 2'h3)) else $error("gate level wrong");
  fast_drop_a:
    assert property (!fast_osc_on |-> ##2 !fast_osc_ready) else $error("fast ready kept after stop");
  fast_settle_a:
    assert property ($rose(fast_osc_ready) |-> $past(fc_r) == fw) else $error("fast wait count wrong");
  slow_settle_a:
    assert property ($rose(slow_osc_ready) |-> $past(sc_r) == sw) else $error("slow wait count wrong");
endmodule // clkgen_assertions
bind clock_output_and_gating_control clkgen_assertions #(
  .SLOW_WAIT_LONG(SLOW_WAIT_LONG), .SLOW_WAIT_SHORT(SLOW_WAIT_SHORT)) chk (.*);
`default_nettype wire

// file: tb/clock_output_and_gating_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_defines.svh"
// Register and clock output tests over classic Wishbone
module clock_output_and_gating_control_tb;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [16:0] wb_adr_i = 17'h00000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, clock_out_a, clock_out_b, core_clock;
  logic        peripheral_clock_on, fast_osc_ready, slow_osc_ready;
  logic        fast_osc_tick = 1'b1;        // Fast ticks every cycle
  logic        fast_osc_on = 1'b1;
  logic        slow_osc_on = 1'b1;
  logic        slow_half = 1'b0;            // Slow ticks every other cycle when set
  logic        slow_ph_r = 1'b0;            // Slow tick phase
  logic [1:0]  system_clock_source = 2'h0;
  wire         slow_osc_tick = slow_half ? slow_ph_r : 1'b1;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc_n = 0;                   // Watchdog cycle count
  int          n, k;
  logic [31:0] rd;                          // Last read data
  logic [14:0] idx [5] = '{`IDX_OUT_A, `IDX_OUT_B, `IDX_SETTLE, `IDX_PCLK_GATE, `IDX_CORE_GEAR};
  logic [7:0]  rst [5] = '{`RST_OUT_A, `RST_OUT_B, `RST_SETTLE, `RST_PCLK_GATE, `RST_CORE_GEAR};
  logic [7:0]  msk [5] = '{8'h7d, 8'h7d, 8'hc3, 8'h03, 8'h03};
  clock_output_and_gating_control #(.SLOW_WAIT_LONG(16), .SLOW_WAIT_SHORT(4)) uut (.*);
  // 50 MHz clock
  initial forever #10 clk_sys = ~clk_sys;
  // Slow tick phase and hang guard
  always @(posedge clk_sys) begin
    slow_ph_r <= ~slow_ph_r;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  // Counted comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One classic cycle; held until ack is seen at an edge
  task automatic wb_cycle(input logic w, input logic [14:0] ix, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {ix, 2'b00};
    wb_sel_i <= s;
    wb_dat_i <= {24'h000000, d};
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [14:0] ix, input logic [7:0] d);
    wb_cycle(1'b1, ix, d, 4'h1);
  endtask
  task automatic rchk(input logic [14:0] ix, input logic [7:0] exp);
    wb_cycle(1'b0, ix, 8'h00, 4'hf);
    chk(rd, {24'h000000, exp});
  endtask
  function automatic logic pick(input int w);
    return (w == 0) ? clock_out_a : (w == 1) ? clock_out_b : core_clock;
  endfunction
  // Cycles between pulses, after two pulses to settle
  task automatic gap(input int w, output int g);
    repeat (2) begin
      g = 0;
      do begin
        @(posedge clk_sys);
        g++;
      end while (pick(w) !== 1'b1 && g < 2000);
    end
    g = 0;
    do begin
      @(posedge clk_sys);
      g++;
    end while (pick(w) !== 1'b1 && g < 2000);
  endtask
  // Pulses seen in a window after the pipeline drains
  task automatic pulses(input int w, output int c);
    c = 0;
    repeat (3) @(posedge clk_sys);
    repeat (300) begin
      @(posedge clk_sys);
      if (pick(w) === 1'b1) c++;
    end
  endtask
  // Stop and restart an oscillator, count edges until ready shows
  task automatic settle(input logic fast, output int c);
    @(posedge clk_sys);
    if (fast) fast_osc_on <= 1'b0;
    else slow_osc_on <= 1'b0;
    repeat (3) @(posedge clk_sys);
    if (fast) fast_osc_on <= 1'b1;
    else slow_osc_on <= 1'b1;
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while ((fast ? fast_osc_ready : slow_osc_ready) !== 1'b1 && c < 100);
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    for (k = 0; k < 5; k++) rchk(idx[k], rst[k]);
    rchk(15'h5066, 8'h00);
    chk(peripheral_clock_on, 1'b1);
    // Let the fast wait run out before its count is rewritten
    while (fast_osc_ready !== 1'b1) @(posedge clk_sys);
    for (k = 0; k < 5; k++) begin
      wr(idx[k], 8'hff);
      rchk(idx[k], msk[k]);
    end
    wr(15'h5066, 8'hff);
    rchk(15'h5066, 8'h00);
    wb_cycle(1'b1, `IDX_OUT_A, 8'h00, 4'h0);
    rchk(`IDX_OUT_A, 8'h7d);
    wr(`IDX_PCLK_GATE, 8'hf3);
    rchk(`IDX_PCLK_GATE, 8'h03);
    wr(`IDX_PCLK_GATE, 8'h00);
    rchk(`IDX_PCLK_GATE, 8'h00);
    chk(peripheral_clock_on, 1'b0);
    wr(`IDX_PCLK_GATE, 8'h03);
    for (k = 0; k < 4; k++) begin
      wr(`IDX_SETTLE, {k[1:0], 6'h00});
      settle(1'b1, n);
      chk(n, (64 >> k) + 2);
    end
    wr(`IDX_SETTLE, 8'h02);
    settle(1'b0, n);
    chk(n, 6);
    wr(`IDX_SETTLE, 8'h00);
    settle(1'b0, n);
    chk(n, 18);
    // Reserved slow code keeps the long wait
    wr(`IDX_SETTLE, 8'h01);
    settle(1'b0, n);
    chk(n, 18);
    for (k = 0; k < 8; k++) begin
      wr(`IDX_OUT_A, {1'b0, k[2:0], 4'h1});
      gap(0, n);
      chk(n, 1 << k);
    end
    slow_half <= 1'b1;
    for (k = 0; k < 8; k++) begin
      wr(`IDX_OUT_B, {1'b0, k[2:0], 4'h5});
      gap(1, n);
      chk(n, 2 << k);
    end
    wr(`IDX_OUT_A, 8'h70);
    pulses(0, n);
    chk(n, 0);
    wr(`IDX_OUT_B, 8'h09);
    pulses(1, n);
    chk(n, 0);
    for (k = 0; k < 4; k++) begin
      wr(`IDX_CORE_GEAR, k[7:0]);
      gap(2, n);
      chk(n, 1 << k);
    end
    system_clock_source <= 2'h1;
    gap(2, n);
    chk(n, 16);
    // Reserved system source falls back to fast ticks
    system_clock_source <= 2'h2;
    gap(2, n);
    chk(n, 8);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rchk(`IDX_CORE_GEAR, 8'h00);
    rchk(`IDX_OUT_B, 8'h00);
    summarize();
  end
endmodule // clock_output_and_gating_control_tb
`default_nettype wire
